// >>> gpdd_top.sv
// Top: APB slave for an eight-bit GPIO port with write-only direction
`timescale 1ns/1ps
module gpdd_top
    import gpdd_pkg::*;
#(
    parameter int PORT_W = GPDD_PORT_W
)(
    input wire logic pclk,                         // Clock, 100 MHz
    input wire logic presetn,                      // Async reset, low
    input wire logic psel,                         // APB select
    input wire logic penable,                      // APB access phase
    input wire logic pwrite,                       // APB direction
    input wire logic [GPDD_ADDR_W-1:0] paddr,      // APB byte address
    input wire logic [31:0] pwdata,                // APB write data
    input wire logic [3:0] pstrb,                  // APB byte strobes
    output logic [31:0] prdata,                    // APB read data
    output logic pready,                           // APB ready
    output logic pslverr,                          // APB error
    input wire logic [GPDD_PORT_W-1:0] port_pin_n_in,  // Pin levels
    output logic [GPDD_PORT_W-1:0] port_pin_n_out,     // Pin drive value
    output logic [GPDD_PORT_W-1:0] port_pin_n_oe       // Pin drive enable
);
    import gpdd_pkg::*;

    // Elaboration check: the register map is built for one byte-wide port
    if (PORT_W != GPDD_PORT_W) begin : g_width_check
        $error("gpdd_top serves only an eight-bit port");
    end

    gpdd_regs_if rif ();

    logic setup;
    logic access;
    logic hit_value;
    logic hit_dir;
    logic hit_pins;
    gpdd_byte_t port_read;

    function automatic gpdd_byte_t gpdd_mix(input gpdd_byte_t dir,
                                            input gpdd_byte_t stored,
                                            input gpdd_byte_t pins);
        // Inputs show the pin, outputs show the latch
        return (dir & stored) | (~dir & pins);
    endfunction

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign hit_value = paddr == GPDD_OFS_VALUE;
    assign hit_dir = paddr == GPDD_OFS_DIR;
    assign hit_pins = paddr == GPDD_OFS_PINS;

    // Zero wait states; lane 0 strobe needed since data sits in low byte
    assign pready = 1'b1;
    assign pslverr = access && !(hit_value || hit_dir || hit_pins);
    assign rif.wdata = pwdata[GPDD_PORT_W-1:0];
    assign rif.wr_value = access && pwrite && hit_value && pstrb[0];
    assign rif.wr_dir = access && pwrite && hit_dir && pstrb[0];

    // Read-modify-write by software sees pins, not the latch, on inputs
    assign port_read = gpdd_mix(rif.dir, rif.value, port_pin_n_in);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= GPDD_UNMAPPED_DATA;
        end else if (setup && !pwrite) begin
            if (hit_value) begin
                prdata <= {24'h000000, port_read};
            end else if (hit_dir) begin
                prdata <= {24'h000000, GPDD_DIR_READBACK};
            end else if (hit_pins) begin
                prdata <= {24'h000000, port_pin_n_in};
            end else begin
                prdata <= GPDD_UNMAPPED_DATA;
            end
        end
    end

    gpdd_port_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .rif(rif)
    );

    // Stored bits on input pins never reach the pad
    assign port_pin_n_oe = rif.dir;
    assign port_pin_n_out = rif.value & rif.dir;

    a_dir_reads_ones: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_dir) |=> prdata[7:0] == 8'hff)
        else $error("direction read not all ones");
    a_read_inputs: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_value) |=>
        ((prdata[7:0] & ~$past(rif.dir)) ==
         ($past(port_pin_n_in) & ~$past(rif.dir))))
        else $error("input bit did not read pin level");
    a_read_outputs: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_value) |=>
        ((prdata[7:0] & $past(rif.dir)) ==
         ($past(rif.value) & $past(rif.dir))))
        else $error("output bit did not read latch");
    a_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (port_pin_n_out & port_pin_n_oe) == (rif.value & rif.dir))
        else $error("output pin not driving latch");
    a_input_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        rif.wr_value |=> (port_pin_n_oe == $past(rif.dir)
                          && (port_pin_n_out & ~port_pin_n_oe) == 8'h00))
        else $error("input pin driven after data write");
    a_dir_write_oe: assert property (@(posedge pclk) disable iff (!presetn)
        rif.wr_dir |=> port_pin_n_oe == $past(pwdata[7:0]))
        else $error("direction write did not reach enables");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !hit_value && !hit_dir && !hit_pins) |-> pslverr)
        else $error("unmapped access without error");
    // Data writes must leave the enables alone in the following cycle
    a_rmw_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        (rif.wr_value && !rif.wr_dir) |=>
        (port_pin_n_oe == $past(rif.dir)))
        else $error("data write disturbed direction");
    a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
        access |-> pready)
        else $error("access phase without ready");
    a_mapped_no_err: assert property (@(posedge pclk) disable iff (!presetn)
        (access && (hit_value || hit_dir || hit_pins)) |-> !pslverr)
        else $error("mapped access flagged as error");
    a_prdata_upper: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite) |=> prdata[31:8] == 24'h000000)
        else $error("read data upper bytes not zero");
    // Read data stands until the next read setup
    a_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(setup && !pwrite) |=> $stable(prdata))
        else $error("read data changed without read");
    a_pins_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_pins) |=>
        prdata[7:0] == $past(port_pin_n_in))
        else $error("raw pin read wrong");
    a_lane_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && !pstrb[0]) |=>
        ($stable(rif.value) && $stable(rif.dir)))
        else $error("write without low lane stored");

    c_dir_read: cover property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && hit_dir);
    c_mixed_read: cover property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && hit_value && rif.dir != 8'h00
        && rif.dir != 8'hff);
    c_rmw: cover property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit_value) ##[1:4] rif.wr_value);
    c_dir_write: cover property (@(posedge pclk) disable iff (!presetn)
        rif.wr_dir);
endmodule // gpdd_top

// >>> gpdd_pkg.sv
// Package: register map, widths and reset values of the GPIO port
package gpdd_pkg;
    localparam int GPDD_PORT_W = 8;
    localparam int GPDD_ADDR_W = 12;
    localparam logic [GPDD_ADDR_W-1:0] GPDD_OFS_VALUE = 12'h000;
    localparam logic [GPDD_ADDR_W-1:0] GPDD_OFS_DIR = 12'h004;
    localparam logic [GPDD_ADDR_W-1:0] GPDD_OFS_PINS = 12'h008;
    localparam logic [GPDD_PORT_W-1:0] GPDD_RST_VALUE = 8'h00;
    localparam logic [GPDD_PORT_W-1:0] GPDD_RST_DIR = 8'h00;
    localparam logic [GPDD_PORT_W-1:0] GPDD_DIR_READBACK = 8'hff;
    localparam logic [31:0] GPDD_UNMAPPED_DATA = 32'h0000_0000;
    typedef logic [GPDD_PORT_W-1:0] gpdd_byte_t;
endpackage

// >>> gpdd_regs_if.sv
// Interface: register write strobes and stored port state
`timescale 1ns/1ps
interface gpdd_regs_if;
    import gpdd_pkg::*;
    logic wr_value;
    logic wr_dir;
    gpdd_byte_t wdata;
    gpdd_byte_t value;
    gpdd_byte_t dir;
    modport bus (output wr_value, output wr_dir, output wdata,
                 input value, input dir);
    modport regs (input wr_value, input wr_dir, input wdata,
                  output value, output dir);
endinterface

// >>> gpdd_port_regs.sv
// Port data and direction registers; pin drive is built in gpdd_top
`timescale 1ns/1ps
module gpdd_port_regs
    import gpdd_pkg::*;
(
    input wire logic pclk,       // Clock
    input wire logic presetn,    // Async reset, low
    gpdd_regs_if.regs rif        // Strobes and state
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rif.value <= GPDD_RST_VALUE;
        end else if (rif.wr_value) begin
            rif.value <= rif.wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rif.dir <= GPDD_RST_DIR;
        end else if (rif.wr_dir) begin
            rif.dir <= rif.wdata;
        end
    end

    a_value_store: assert property (@(posedge pclk) disable iff (!presetn)
        rif.wr_value |=> rif.value == $past(rif.wdata))
        else $error("port value not stored");
    a_dir_store: assert property (@(posedge pclk) disable iff (!presetn)
        rif.wr_dir |=> rif.dir == $past(rif.wdata))
        else $error("direction byte not stored");
    a_dir_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !rif.wr_dir |=> $stable(rif.dir))
        else $error("direction changed without write");
endmodule // gpdd_port_regs

// >>> gpdd_core_model.sv
// Processor core model: APB master that drives the port registers
`timescale 1ns/1ps
module gpdd_core_model (
    input wire logic pclk,                          // Clock
    output logic psel,                              // APB select
    output logic penable,                           // APB access phase
    output logic pwrite,                            // APB direction
    output logic [gpdd_pkg::GPDD_ADDR_W-1:0] paddr, // APB address
    output logic [31:0] pwdata,                     // APB write data
    output logic [3:0] pstrb,                       // Low lane only
    input wire logic [31:0] prdata,                 // APB read data
    input wire logic pready                         // APB ready
);
    import gpdd_pkg::*;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h1;
    end
    // One full transfer; request held until pready seen high
    task automatic xfer(input logic w, input logic [GPDD_ADDR_W-1:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // gpdd_core_model

// >>> gpio_port_data_direction_test.sv
// Self-checking bench for the GPIO port data and direction block
`timescale 1ns/1ps
module gpio_port_data_direction_test;
    import gpdd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [3:0] pstrb;
    logic [GPDD_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    gpdd_byte_t pins = 8'h00;
    gpdd_byte_t pout, poe, d, v;
    logic [31:0] exp_q[$];
    int fail_count = 0;
    int n_tests = 0;
    gpdd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_pin_n_in(pins), .port_pin_n_out(pout), .port_pin_n_oe(poe));
    gpdd_core_model core (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready));
    initial forever #5 pclk = ~pclk;
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        core.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic wr(input logic [11:0] a, input gpdd_byte_t x);
        core.xfer(1'b1, a, {24'h0, x}, q);
    endtask
    // Bit change the way the core does it: whole byte read back first
    task automatic rmw(input logic [11:0] a, input int b, input logic s,
                       input gpdd_byte_t e);
        rd(a, {24'h0, e});
        q[b] = s;
        wr(a, q[7:0]);
    endtask
    task automatic pin_chk(input gpdd_byte_t o, input gpdd_byte_t e);
        @(negedge pclk);
        chk("oe", {24'h0, o}, {24'h0, poe});
        chk("out", {24'h0, e}, {24'h0, pout});
    endtask
    // Read results are judged where they complete on the bus
    always @(posedge pclk) begin
        if (psel && penable && pready)
            chk("pslverr", {31'h0, paddr == 12'hffc}, {31'h0, pslverr});
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0)
                chk("queue", 32'h1, 32'h0);
            else
                chk("prdata", exp_q.pop_front(), prdata);
        end
    end
    initial begin
        repeat (3000) @(posedge pclk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'ha75c));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(GPDD_OFS_DIR, 32'hff);
        pin_chk(8'h00, 8'h00);
        @(posedge pclk);
        pins <= 8'h40;
        wr(GPDD_OFS_DIR, 8'h3f);
        wr(GPDD_OFS_VALUE, 8'h81);
        pin_chk(8'h3f, 8'h01);
        rmw(GPDD_OFS_VALUE, 1, 1'b1, 8'h41);
        pin_chk(8'h3f, 8'h03);
        wr(GPDD_OFS_DIR, 8'hff);
        pin_chk(8'hff, 8'h43);
        rmw(GPDD_OFS_DIR, 1, 1'b0, 8'hff);
        pin_chk(8'hfd, 8'h41);
        rd(12'hffc, GPDD_UNMAPPED_DATA);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            v = 8'($urandom);
            @(posedge pclk);
            pins <= 8'($urandom);
            wr(GPDD_OFS_DIR, d);
            wr(GPDD_OFS_VALUE, v);
            pin_chk(d, v & d);
            rd(GPDD_OFS_VALUE, {24'h0, (v & d) | (pins & ~d)});
        end
        repeat (2) @(posedge pclk);
        tally_and_finish();
    end
endmodule // gpio_port_data_direction_test
